//--- rtl/smsc_ctrl.sv
// spi master/slave controller: shift engines, packing, compare and fifos
`timescale 1ns/1ps
`default_nettype none
module smsc_ctrl #(
   parameter int W     = smsc_pkg::WORD_W,
   parameter int DEPTH = smsc_pkg::FIFO_DEPTH
) (
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire logic                        master_en,
   input  wire logic                        sw_select_mode,
   input  wire logic                        sw_select,
   input  wire logic                        cs_index,
   input  wire logic                        cpol,
   input  wire logic                        cpha,
   input  wire logic [smsc_pkg::LEN_W-1:0]  len_m1,
   input  wire logic                        pack_en,
   input  wire logic                        cmp_en,
   input  wire logic [W-1:0]                cmp_pattern,
   input  wire logic [smsc_pkg::DIV_W-1:0]  clk_half_div,
   input  wire logic                        clr_overrun,
   input  wire logic [W-1:0]                tx_data,
   input  wire logic                        tx_valid,
   output logic                             tx_ready,
   output logic [W-1:0]                     rx_data,
   output logic                             rx_valid,
   input  wire logic                        rx_ready,
   output logic                             busy,
   output logic                             cmp_matched,
   output logic                             rx_overrun,
   input  wire logic                        sck_in,
   output logic                             sck_out,
   output logic                             sck_oe,
   input  wire logic                        mosi_in,
   output logic                             mosi_out,
   output logic                             mosi_oe,
   input  wire logic                        miso_in,
   output logic                             miso_out,
   output logic                             miso_oe,
   input  wire logic                        port2_select_n_in,
   output logic [1:0]                       port2_select_n,
   output logic                             port2_select_n_oe
);
   localparam int LW = smsc_pkg::LEN_W;
   localparam int TW = smsc_pkg::TCNT_W;

   typedef enum logic [2:0] {
      SMSC_IDLE,
      SMSC_SETUP,
      SMSC_SHIFT,
      SMSC_HOLD,
      SMSC_GAP
   } smsc_state_t;

   typedef struct packed {
      smsc_state_t                   st;
      logic [smsc_pkg::DIV_W-1:0]    div_cnt;
      logic [LW:0]                   edge_cnt;
      logic [TW-1:0]                 tcnt;
      logic                          sck;
      logic                          mosi;
      logic                          sel_act;
      logic [W-1:0]                  tx_sr;
      logic [W-1:0]                  rx_sr;
      logic [W-1:0]                  tx_word;
      logic                          tx_have;
      logic [LW-1:0]                 tx_idx;
      logic [W-1:0]                  rx_acc;
      logic [LW-1:0]                 rx_idx;
      logic                          push;
      logic [W-1:0]                  rx_out;
      logic                          matched;
      logic                          overrun;
      logic [W-1:0]                  slv_tx;
      logic                          reload;
      logic                          tgl_prev;
   } smsc_ctrl_t;

   typedef struct packed {
      logic [W-1:0] rx_sr;
      logic [W-1:0] rx_hold;
      logic         done_tgl;
   } smsc_link_t;

   smsc_ctrl_t      q;
   smsc_ctrl_t      d;
   smsc_link_t      lk_q;
   smsc_link_t      lk_d;
   logic [LW-1:0]   bit_cnt_q;
   logic            miso_q;
   logic            slv_clk;
   logic            link_clr;
   logic [2:0]      sync_in;
   logic [2:0]      sync_out;
   logic            miso_s;
   logic            sel_idle_s;
   logic            tgl_s;
   logic            tx_pop;
   logic            pkt_done;
   logic [W-1:0]    pkt_val;
   logic [W-1:0]    msk;
   logic [LW-1:0]   ppw;
   logic [W-1:0]    cur_pkt;
   logic [W-1:0]    acc;
   logic            leading;

   smsc_stream_if #(.W(W)) tx_in  ();
   smsc_stream_if #(.W(W)) tx_out ();
   smsc_stream_if #(.W(W)) rx_in  ();
   smsc_stream_if #(.W(W)) rx_out ();

   // two independent fifos; the rx side stalls the master when full
   smsc_fifo #(.W(W), .DEPTH(DEPTH)) u_tx_fifo (
      .clk (mclk),
      .rst (rst),
      .wr  (tx_in),
      .rd  (tx_out)
   );

   smsc_fifo #(.W(W), .DEPTH(DEPTH)) u_rx_fifo (
      .clk (mclk),
      .rst (rst),
      .wr  (rx_in),
      .rd  (rx_out)
   );

   assign tx_in.valid  = tx_valid;
   assign tx_in.data   = tx_data;
   assign tx_ready     = tx_in.ready;
   assign tx_out.ready = tx_pop;
   assign rx_in.valid  = q.push;
   assign rx_in.data   = q.rx_out;
   assign rx_valid     = rx_out.valid;
   assign rx_data      = rx_out.data;
   assign rx_out.ready = rx_ready;

   // pins and the slave done toggle reach mclk logic through two flops
   assign sync_in = {lk_q.done_tgl, port2_select_n_in, miso_in};

   smsc_sync #(.W(3)) u_sync (
      .clk (mclk),
      .rst (rst),
      .d   (sync_in),
      .q   (sync_out)
   );

   assign miso_s     = sync_out[0];
   assign sel_idle_s = sync_out[1];
   assign tgl_s      = sync_out[2];

   assign msk     = smsc_pkg::len_mask(len_m1);
   assign ppw     = smsc_pkg::pkts_per_word(len_m1, pack_en);
   assign cur_pkt = (q.tx_word >> smsc_pkg::pkt_shift(q.tx_idx, len_m1)) & msk;

   always_comb begin
      d        = q;
      tx_pop   = 1'b0;
      pkt_done = 1'b0;
      pkt_val  = '0;
      acc      = '0;
      leading  = ~q.edge_cnt[0];
      d.push   = 1'b0;
      if (!q.tx_have && tx_out.valid) begin
         d.tx_word = tx_out.data;
         d.tx_have = 1'b1;
         d.tx_idx  = '0;
         tx_pop    = 1'b1;
      end
      unique case (q.st)
         SMSC_IDLE: begin
            d.sck = cpol;
            // no clocks until there is a packet to send and room to land it
            if (master_en && q.tx_have && rx_in.ready) begin
               d.tx_sr    = cur_pkt << (smsc_pkg::LEN_MAX - len_m1);
               d.rx_sr    = '0;
               d.sel_act  = 1'b1;
               d.edge_cnt = '0;
               d.tcnt     = smsc_pkg::SETUP_CYC;
               d.st       = SMSC_SETUP;
            end
         end
         SMSC_SETUP: begin
            if (q.tcnt <= TW'(1)) begin
               d.div_cnt = '0;
               d.st      = SMSC_SHIFT;
               // phase 0 puts the first bit out before the leading edge
               if (!cpha) begin
                  d.mosi  = q.tx_sr[W-1];
                  d.tx_sr = {q.tx_sr[W-2:0], 1'b0};
               end
            end else begin
               d.tcnt = q.tcnt - TW'(1);
            end
         end
         SMSC_SHIFT: begin
            // half period set by clk_half_div; rate limited by mclk
            if (q.div_cnt >= clk_half_div - smsc_pkg::DIV_W'(1)) begin
               d.div_cnt  = '0;
               d.sck      = ~q.sck;
               d.edge_cnt = q.edge_cnt + (LW+1)'(1);
               if (leading != cpha) begin
                  d.rx_sr = {q.rx_sr[W-2:0], miso_s};
               end else begin
                  d.mosi  = q.tx_sr[W-1];
                  d.tx_sr = {q.tx_sr[W-2:0], 1'b0};
               end
               if (q.edge_cnt == {len_m1, 1'b1}) begin
                  d.tcnt = smsc_pkg::HOLD_CYC;
                  d.st   = SMSC_HOLD;
               end
            end else begin
               d.div_cnt = q.div_cnt + smsc_pkg::DIV_W'(1);
            end
         end
         SMSC_HOLD: begin
            if (q.tcnt <= TW'(1)) begin
               pkt_done  = 1'b1;
               pkt_val   = q.rx_sr;
               d.sel_act = 1'b0;
               d.tcnt    = smsc_pkg::GAP_CYC;
               d.st      = SMSC_GAP;
            end else begin
               d.tcnt = q.tcnt - TW'(1);
            end
         end
         SMSC_GAP: begin
            if (q.tcnt <= TW'(1)) begin
               d.st = SMSC_IDLE;
            end else begin
               d.tcnt = q.tcnt - TW'(1);
            end
         end
      endcase
      if (!master_en && (tgl_s != q.tgl_prev)) begin
         pkt_done = 1'b1;
         pkt_val  = lk_q.rx_hold;
      end
      d.tgl_prev = tgl_s;
      if (pkt_done) begin
         if (q.tx_have) begin
            if (q.tx_idx == ppw - LW'(1)) begin
               d.tx_have = 1'b0;
            end else begin
               d.tx_idx = q.tx_idx + LW'(1);
            end
         end
         if (cmp_en && !q.matched) begin
            // the matching packet itself is not stored
            if ((pkt_val & msk) == (cmp_pattern & msk)) begin
               d.matched = 1'b1;
            end
         end else begin
            acc = q.rx_acc | ((pkt_val & msk) << smsc_pkg::pkt_shift(q.rx_idx, len_m1));
            if (q.rx_idx == ppw - LW'(1)) begin
               d.push   = 1'b1;
               d.rx_out = acc;
               d.rx_acc = '0;
               d.rx_idx = '0;
            end else begin
               d.rx_acc = acc;
               d.rx_idx = q.rx_idx + LW'(1);
            end
         end
      end
      if (!cmp_en) begin
         d.matched = 1'b0;
      end
      // a slave cannot stall the far master, so a full rx fifo drops the word
      d.overrun = (q.overrun & ~clr_overrun) | (q.push & ~rx_in.ready);
      // slave transmit packet only changes between packets
      d.reload = pkt_done;
      if (sel_idle_s || q.reload) begin
         d.slv_tx = q.tx_have ? cur_pkt : '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q       <= '0;
         q.st    <= SMSC_IDLE;
      end else begin
         q <= d;
      end
   end

   // link side: runs on the external clock, sample edge made rising
   assign slv_clk  = sck_in ^ (cpol ^ cpha);
   // the frame's own select ends a packet, whatever the link clock does
   assign link_clr = rst | port2_select_n_in;

   always_ff @(posedge slv_clk or posedge link_clr) begin
      if (link_clr) begin
         bit_cnt_q <= '0;
      end else begin
         bit_cnt_q <= (bit_cnt_q == len_m1) ? '0 : bit_cnt_q + LW'(1);
      end
   end

   always_comb begin
      lk_d       = lk_q;
      lk_d.rx_sr = {lk_q.rx_sr[W-2:0], mosi_in};
      if (bit_cnt_q == len_m1) begin
         lk_d.rx_hold  = {lk_q.rx_sr[W-2:0], mosi_in};
         lk_d.done_tgl = ~lk_q.done_tgl;
      end
   end

   // rx_hold stays steady a whole packet, long enough for mclk to take it
   always_ff @(posedge slv_clk or posedge rst) begin
      if (rst) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   always_ff @(negedge slv_clk or posedge link_clr) begin
      if (link_clr) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= q.slv_tx[len_m1 - bit_cnt_q];
      end
   end

   // pin drivers
   assign sck_out  = q.sck;
   assign sck_oe   = master_en;
   assign mosi_out = q.mosi;
   assign mosi_oe  = master_en;
   assign miso_out = (bit_cnt_q == '0) ? q.slv_tx[len_m1] : miso_q;
   assign miso_oe  = ~master_en & ~port2_select_n_in;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         port2_select_n[i] = ~((sw_select_mode ? sw_select : q.sel_act)
                               & (cs_index == i[0]));
      end
   end

   assign port2_select_n_oe = master_en;
   assign busy              = (q.st != SMSC_IDLE) | ~sel_idle_s;
   assign cmp_matched       = q.matched;
   assign rx_overrun        = q.overrun;

endmodule : smsc_ctrl
`default_nettype wire

//--- rtl/smsc_pkg.sv
// shared constants, timing counts and helper functions for the spi controller
package smsc_pkg;

   localparam int WORD_W     = 32;
   localparam int LEN_W      = 5;
   localparam int FIFO_DEPTH = 4;
   localparam int DIV_W      = 8;
   localparam int TCNT_W     = 4;

   // documented serial ceilings, kept for reference by integrators
   localparam int MASTER_MAX_MBPS = 65;
   localparam int SLAVE_MAX_MBPS  = 45;

   // lengths (value minus one) that allow packing, and the longest length
   localparam logic [LEN_W-1:0] PACK_LEN_8  = 5'h07;
   localparam logic [LEN_W-1:0] PACK_LEN_16 = 5'h0F;
   localparam logic [LEN_W-1:0] LEN_MAX     = 5'h1F;

   localparam logic [LEN_W-1:0] PPW_8  = 5'h04;
   localparam logic [LEN_W-1:0] PPW_16 = 5'h02;
   localparam logic [LEN_W-1:0] PPW_1  = 5'h01;

   localparam logic [DIV_W-1:0] HALF_DIV_RST = 8'h04;

   // select timing in ns and the derived mclk counts
   localparam int CLK_NS  = 25;
   localparam int TCSS_NS = 2;
   localparam int TCSH_NS = 3;
   localparam int TCS_NS  = 10;

   function automatic int cyc_up(int t_ns);
      int c;
      c = (t_ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up

   localparam logic [TCNT_W-1:0] SETUP_CYC = TCNT_W'(cyc_up(TCSS_NS));
   localparam logic [TCNT_W-1:0] HOLD_CYC  = TCNT_W'(cyc_up(TCSH_NS));
   localparam logic [TCNT_W-1:0] GAP_CYC   = TCNT_W'(cyc_up(TCS_NS));

   function automatic logic [WORD_W-1:0] len_mask(logic [LEN_W-1:0] len_m1);
      return 32'hFFFFFFFF >> (LEN_MAX - len_m1);
   endfunction : len_mask

   function automatic logic [LEN_W-1:0] pkts_per_word(logic [LEN_W-1:0] len_m1,
                                                      logic             pack);
      if (pack && len_m1 == PACK_LEN_8) return PPW_8;
      if (pack && len_m1 == PACK_LEN_16) return PPW_16;
      return PPW_1;
   endfunction : pkts_per_word

   function automatic logic [LEN_W-1:0] pkt_shift(logic [LEN_W-1:0] idx,
                                                  logic [LEN_W-1:0] len_m1);
      logic [9:0] p;
      p = 10'(idx) * (10'(len_m1) + 10'h001);
      return p[LEN_W-1:0];
   endfunction : pkt_shift

endpackage : smsc_pkg

//--- rtl/smsc_stream_if.sv
// valid/ready word stream between the controller and its fifos
`timescale 1ns/1ps
`default_nettype none
interface smsc_stream_if #(
   parameter int W = 32
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : smsc_stream_if
`default_nettype wire

//--- rtl/smsc_sync.sv
// two flip-flop synchroniser for single-bit levels
`timescale 1ns/1ps
`default_nettype none
module smsc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } smsc_sync_t;

   smsc_sync_t st_q;
   smsc_sync_t st_d;

   always_comb begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule : smsc_sync
`default_nettype wire

//--- rtl/smsc_fifo.sv
// flop-based synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module smsc_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 4
) (
   input  wire logic clk,
   input  wire logic rst,
   smsc_stream_if.snk wr,
   smsc_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } smsc_fifo_t;

   smsc_fifo_t st_q;
   smsc_fifo_t st_d;
   logic       do_wr;
   logic       do_rd;

   assign wr.ready = (st_q.cnt != (AW+1)'(DEPTH));
   assign rd.valid = (st_q.cnt != '0);
   assign rd.data  = st_q.mem[st_q.rp];
   assign do_wr    = wr.valid & wr.ready;
   assign do_rd    = rd.valid & rd.ready;

   always_comb begin
      st_d = st_q;
      if (do_wr) begin
         st_d.mem[st_q.wp] = wr.data;
         st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + AW'(1);
      end
      if (do_rd) begin
         st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + AW'(1);
      end
      st_d.cnt = st_q.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule : smsc_fifo
`default_nettype wire

//--- dv/smsc_peer.sv
// behavioural spi slave device: answers a fixed word msb first, records what it receives
`timescale 1ns/1ps
`default_nettype none
module smsc_peer #(
   parameter logic [31:0] RESP = 32'hC3A596E1
) (
   input  wire logic sel_n,
   input  wire logic sck,
   input  wire logic mosi,
   input  wire logic cpol,
   input  wire logic cpha,
   input  wire logic slow,
   output logic      miso
);
   logic [31:0] sh;
   logic [31:0] acc;
   logic [31:0] got[$];
   initial miso = 1'b0;
   always @(negedge sel_n) begin
      sh  = RESP;
      acc = 32'h0;
      if (!cpha) begin
         miso <= #(slow ? 10 : 1) sh[31];
         sh = sh << 1;
      end
   end
   // no pull on the line, so a released miso shows the wrong level
   always @(posedge sel_n) begin
      got.push_back(acc);
      miso <= ~miso;
   end
   always @(sck) begin
      if (!sel_n) begin
         if ((sck != cpol) ^ cpha) begin
            acc = {acc[30:0], mosi};
         end else begin
            miso <= #(slow ? 10 : 1) sh[31];
            sh = sh << 1;
         end
      end
   end
endmodule : smsc_peer
`default_nettype wire

//--- dv/smsc_ctrl_asserts.sv
// concurrent checks on the controller pins and flags
`timescale 1ns/1ps
`default_nettype none
module smsc_ctrl_asserts (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       master_en,
   input wire logic       sw_select_mode,
   input wire logic       sw_select,
   input wire logic       cs_index,
   input wire logic       cpol,
   input wire logic       cpha,
   input wire logic       cmp_en,
   input wire logic       rx_valid,
   input wire logic       busy,
   input wire logic       cmp_matched,
   input wire logic       sck_out,
   input wire logic       sck_oe,
   input wire logic       mosi_out,
   input wire logic       mosi_oe,
   input wire logic       miso_oe,
   input wire logic       port2_select_n_in,
   input wire logic [1:0] port2_select_n,
   input wire logic       port2_select_n_oe
);
   logic sel;
   logic hw;
   assign sel = !port2_select_n[cs_index];
   // framing checks only in hardware mode; software may hold the select
   assign hw  = master_en && !sw_select_mode;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   chk_pin_enables: assert property (
      $stable(master_en) && !$past(rst) |-> sck_oe == master_en && mosi_oe == master_en
      && port2_select_n_oe == master_en) else $error("pin enables wrong");
   chk_miso_enable: assert property (
      miso_oe == (!master_en && !port2_select_n_in)) else $error("miso enable wrong");
   chk_unused_select: assert property (
      hw && $stable(cs_index) |-> port2_select_n[~cs_index]) else $error("wrong select");
   chk_sw_select: assert property (
      master_en && sw_select_mode |-> port2_select_n[cs_index] == !sw_select
      && port2_select_n[~cs_index]) else $error("software select wrong");
   chk_sck_idle: assert property (
      hw && !sel && $stable(cpol) && !$past(rst) |-> sck_out == cpol)
      else $error("idle clock level wrong");
   chk_mosi_hold: assert property (
      master_en && sel && $changed(sck_out) && sck_out == (cpol ~^ cpha) |-> $stable(mosi_out))
      else $error("mosi moved on sample edge");
   chk_setup_quiet: assert property (
      hw && $fell(port2_select_n[cs_index]) && $stable(cs_index) |-> (sck_out == cpol) [*2])
      else $error("clock before select setup");
   chk_gap_high: assert property (
      hw && $rose(port2_select_n[cs_index]) && $stable(cs_index) |-> port2_select_n[cs_index] [*2])
      else $error("select gap too short");
   chk_busy_select: assert property (
      hw && sel |-> busy) else $error("select low while idle");
   chk_cmp_store: assert property (
      cmp_en && $rose(rx_valid) |-> cmp_matched) else $error("stored before match");
   chk_cmp_clear: assert property (
      !cmp_en |=> !cmp_matched) else $error("match flag not cleared");

   cov_master_frame: cover property (hw && $fell(port2_select_n[cs_index]));
   cov_slave_frame: cover property (!master_en && !port2_select_n_in && busy);
   cov_match: cover property ($rose(cmp_matched));
endmodule : smsc_ctrl_asserts

bind smsc_ctrl smsc_ctrl_asserts u_chk (
   .mclk, .rst, .master_en, .sw_select_mode, .sw_select, .cs_index, .cpol, .cpha, .cmp_en,
   .rx_valid, .busy, .cmp_matched, .sck_out, .sck_oe, .mosi_out, .mosi_oe, .miso_oe,
   .port2_select_n_in, .port2_select_n, .port2_select_n_oe
);
`default_nettype wire

//--- dv/smsc_ctrl_tb.sv
// self-checking bench: master packets against the peer model, slave frames from the bench
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module smsc_ctrl_tb;
   localparam logic [31:0] RESP = 32'hC3A596E1;
   logic        mclk, rst, master_en, sw_select_mode, sw_select, cs_index, cpol, cpha, slow;
   logic        pack_en, cmp_en, clr_overrun, tx_valid, tx_ready, rx_valid, rx_ready, busy;
   logic        cmp_matched, rx_overrun, sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe;
   logic        miso_in, miso_out, miso_oe, port2_select_n_in, port2_select_n_oe;
   logic [1:0]  port2_select_n;
   logic [4:0]  len_m1;
   logic [4:0]  l;
   logic [7:0]  clk_half_div;
   logic [15:0] lfsr_q;
   logic [31:0] cmp_pattern, tx_data, rx_data, g, e;
   int          checks = 0;
   int          miscompares = 0;
   int          i, j, n;

   smsc_ctrl u_dut (
      .mclk, .rst, .master_en, .sw_select_mode, .sw_select, .cs_index, .cpol, .cpha,
      .len_m1, .pack_en, .cmp_en, .cmp_pattern, .clk_half_div, .clr_overrun, .tx_data,
      .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .busy, .cmp_matched,
      .rx_overrun, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in,
      .miso_out, .miso_oe, .port2_select_n_in, .port2_select_n, .port2_select_n_oe
   );
   smsc_peer #(.RESP(RESP)) u_peer (
      .sel_n(port2_select_n[cs_index]), .sck(sck_out), .mosi(mosi_out), .cpol, .cpha,
      .slow, .miso(miso_in)
   );

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   function automatic logic [31:0] rnd();
      repeat (2) lfsr_q = {lfsr_q[14:0], ^(lfsr_q & 16'hB400)};
      return {lfsr_q, lfsr_q ^ 16'h5A5A};
   endfunction : rnd

   function automatic logic [31:0] mask(input logic [4:0] ln);
      return 32'hFFFFFFFF >> (31 - ln);
   endfunction : mask

   // peer answers the top bits of its word in every packet, packed from bit 0 up
   function automatic logic [31:0] exp_rx(input logic [4:0] ln, input int np);
      logic [31:0] r;
      r = 32'h0;
      for (int k = 0; k < np; k++) r |= (RESP >> (31 - ln)) << (k * (ln + 1));
      return r;
   endfunction : exp_rx

   task automatic step();
      @(posedge mclk);
      #2;
   endtask : step

   task automatic push(input logic [31:0] d, input logic last);
      int k;
      tx_data  = d;
      tx_valid = 1'b1;
      for (k = 0; k < 4000; k++) begin
         @(negedge mclk);
         if (tx_ready === 1'b1) break;
      end
      // a write that is never taken counts against the run
      if (k == 4000) miscompares++;
      step();
      if (last) tx_valid = 1'b0;
   endtask : push

   task automatic pop(input logic [31:0] x);
      int k;
      for (k = 0; k < 4000; k++) begin
         @(negedge mclk);
         if (rx_valid === 1'b1) break;
      end
      if (k == 4000) miscompares++;
      `CHK(rx_data, x)
      step();
   endtask : pop

   task automatic peer_chk(input logic [31:0] d, input logic [4:0] ln, input int np);
      int k;
      for (k = 0; k < 600 && u_peer.got.size() < np; k++) step();
      if (u_peer.got.size() < np) miscompares++;
      for (k = 0; k < np; k++) begin
         g = u_peer.got.pop_front();
         `CHK(g & mask(ln), (d >> (k * (ln + 1))) & mask(ln))
      end
   endtask : peer_chk

   task automatic mxfer(input logic [4:0] ln, input int np, input logic [31:0] d);
      len_m1 = ln;
      step();
      push(d, 1'b1);
      pop(exp_rx(ln, np));
      peer_chk(d, ln, np);
   endtask : mxfer

   task automatic final_report();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   // the whole run needs a few thousand cycles; this leaves ample margin
   initial begin
      #500000;
      miscompares++;
      final_report();
   end

   initial begin
      {master_en, sw_select_mode, sw_select, cs_index, cpol, cpha, pack_en, cmp_en} = 8'h80;
      {clr_overrun, tx_valid, rx_ready, sck_in, mosi_in, slow} = 6'h00;
      {rst, port2_select_n_in} = 2'h3;
      {len_m1, clk_half_div, cmp_pattern, tx_data} = {5'h07, 8'h03, 32'h0, 32'h0};
      lfsr_q = 16'hF25F;
      repeat (12) @(posedge mclk);
      #2;
      rst = 1'b0;
      u_peer.got.delete();
      `CHK(tx_ready, 1'b1)
      `CHK(rx_valid, 1'b0)
      rx_ready = 1'b1;
      for (i = 0; i < 8; i++) begin
         {slow, cpha, cpol} = i[2:0];
         cs_index = i[0] ^ i[1];
         clk_half_div = 8'h03 + 8'(i[2]);
         l = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'(rnd());
         mxfer(l, 1, rnd());
      end
      pack_en = 1'b1;
      mxfer(5'h07, 4, rnd());
      mxfer(5'h0F, 2, rnd());
      {pack_en, len_m1} = 6'h07;
      {sw_select_mode, sw_select, cs_index} = 3'h7;
      step();
      `CHK(port2_select_n, 2'h1)
      sw_select = 1'b0;
      step();
      `CHK(port2_select_n, 2'h3)
      sw_select_mode = 1'b0;
      u_peer.got.delete();
      // receive side stalls: the engine must stop once the rx fifo is full
      rx_ready = 1'b0;
      for (i = 0; i < 6; i++) push(32'(i) * 32'h29, i == 5);
      repeat (800) step();
      `CHK(u_peer.got.size(), smsc_pkg::FIFO_DEPTH)
      rx_ready = 1'b1;
      for (i = 0; i < 6; i++) pop(RESP >> 24);
      for (i = 0; i < 6; i++) peer_chk(32'(i) * 32'h29, 5'h07, 1);
      cmp_pattern = RESP >> 24;
      cmp_en = 1'b1;
      push(32'h5A, 1'b0);
      push(32'hA5, 1'b1);
      pop(RESP >> 24);
      rx_ready = 1'b0;
      `CHK(cmp_matched, 1'b1)
      peer_chk(32'h5A, 5'h07, 1);
      peer_chk(32'hA5, 5'h07, 1);
      repeat (8) step();
      `CHK(rx_valid, 1'b0)
      {cmp_en, master_en, cpol, cpha, rx_ready, tx_valid} = 6'h03;
      n = 0;
      for (i = 0; i < 10; i++) begin
         tx_data = 32'hA6 + 32'(n);
         @(negedge mclk);
         if (tx_ready === 1'b1) n++;
         step();
      end
      tx_valid = 1'b0;
      `CHK(n >= smsc_pkg::FIFO_DEPTH && n <= smsc_pkg::FIFO_DEPTH + 1, 1'b1)
      port2_select_n_in = 1'b0;
      #30;
      for (j = 7; j >= 0; j--) begin
         mosi_in = RESP[24 + j];
         #15;
         sck_in = 1'b1;
         e[j] = miso_out;
         #15;
         sck_in = 1'b0;
      end
      #15;
      port2_select_n_in = 1'b1;
      mosi_in = ~mosi_in;
      `CHK(e[7:0], 8'hA6)
      pop(RESP >> 24);
      `CHK(rx_overrun, 1'b0)
      final_report();
   end
endmodule : smsc_ctrl_tb
`default_nettype wire
